/* gim_chk_assertions.sv */
// concurrent checks on the register bank ports
`timescale 1ns/100ps
module gim_chk (
  input wire clk, input wire rst_b, input wire [15:0] reg_addr,
  input wire reg_wr, input wire reg_rd, input wire [31:0] reg_wdata,
  input wire [31:0] reg_rdata, input wire [6:0] port_irq_stat, input wire irq_out,
  input wire miim_pre_sup, input wire ref_clock_out_en, input wire ref_clock_out_125,
  input wire inband_mgmt_en, input wire inband_mgmt_mac_chk, input wire inband_mgmt_reset,
  input wire [1:0] inband_mgmt_queue, input wire [2:0] inband_mgmt_port,
  input wire inband_mgmt_port_ok, input wire [15:0] inband_mgmt_etype
);
  // ****************
  // properties
  // ****************
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);
  sequence s_wr(a); reg_wr && reg_addr == a; endsequence
  sequence s_pulse; inband_mgmt_reset ##1 !inband_mgmt_reset; endsequence
  property p_stat; reg_rd && reg_addr == 16'h0018 |=> reg_rdata == {25'h0, $past(port_irq_stat)}; endproperty
  a_stat: assert property (p_stat) else $error("port status read wrong");
  property p_irq; irq_out |-> $past(port_irq_stat) != 7'h00; endproperty
  a_irq: assert property (p_irq) else $error("irq without pending port");
  property p_pre; s_wr(16'h0100) |=> ##1 miim_pre_sup == $past(reg_wdata[2], 2); endproperty
  a_pre: assert property (p_pre) else $error("preamble bit wrong");
  property p_ock; s_wr(16'h0103) |=> ##1 {ref_clock_out_en, ref_clock_out_125} == $past(reg_wdata[1:0], 2); endproperty
  a_ock: assert property (p_ock) else $error("clock out control wrong");
  property p_en; s_wr(16'h0104) |=> ##1 inband_mgmt_en == $past(reg_wdata[31], 2); endproperty
  a_en: assert property (p_en) else $error("inband enable wrong");
  property p_mac; s_wr(16'h0104) |=> ##1 inband_mgmt_mac_chk == $past(reg_wdata[30], 2); endproperty
  a_mac: assert property (p_mac) else $error("mac check wrong");
  property p_rst; s_wr(16'h0104) ##0 reg_wdata[29] |=> s_pulse; endproperty
  a_rst: assert property (p_rst) else $error("reset pulse wrong");
  property p_que; s_wr(16'h0104) |=> ##1 inband_mgmt_queue == $past(reg_wdata[23:22], 2); endproperty
  a_que: assert property (p_que) else $error("queue wrong");
  property p_ok; inband_mgmt_port_ok == (inband_mgmt_port != 3'h7); endproperty
  a_ok: assert property (p_ok) else $error("port code flag wrong");
  property p_ety; s_wr(16'h0104) |=> ##1 inband_mgmt_etype == $past(reg_wdata[15:0], 2); endproperty
  a_ety: assert property (p_ety) else $error("ethertype wrong");
endmodule
bind gim_regbank gim_chk u_chk (.clk, .rst_b, .reg_addr, .reg_wr, .reg_rd, .reg_wdata, .reg_rdata,
  .port_irq_stat, .irq_out, .miim_pre_sup, .ref_clock_out_en, .ref_clock_out_125, .inband_mgmt_en,
  .inband_mgmt_mac_chk, .inband_mgmt_reset, .inband_mgmt_queue, .inband_mgmt_port,
  .inband_mgmt_port_ok, .inband_mgmt_etype);

/* gim_port_src.sv */
// port interrupt and strap source standing in for the switch ports
`timescale 1ns/100ps
module gim_port_src (
  input wire [6:0] pend,
  input wire strap_want,
  input wire i2c_mode,
  output wire [6:0] port_irq_stat,
  output wire port7_rx_strap_pin
);
  assign port_irq_stat = pend;
  // in-band stays off while managed over i2c
  assign port7_rx_strap_pin = strap_want & ~i2c_mode;
endmodule

/* gim_regbank.v */
// global io control and port interrupt mask register bank
// How it works
// - mask bits 6..0 block ports one to seven when one; reset zero
// - port status bits 6..0 read only, one while that port requests
// - preamble suppression bit lets miim answer commands lacking a preamble
// - auto edge set: rising edge at fast clock, falling below, manual ignored
// - auto edge clear: manual bit zero falling, one rising; reset zero
// - reference clock output enable resets one; freq bit 25 or 125 MHz
// - inband_mgmt enable read-write, reset value from port seven strap pin
// - mac check bit makes frames with foreign destination address discarded
// - writing one to bit 29 resets inband_mgmt machine then self-clears
// - bits 23:22 pick response priority queue, reset 01
// - bits 18:16 pick inband_mgmt port, 111 reserved, reset 110
// - bits 15:0 hold header ethertype, reset 40fe, rewritable
`timescale 1ns/100ps
`include "gim_regs.vh"
module gim_regbank (
  clk,
  rst_b,
  reg_addr,
  reg_wr,
  reg_rd,
  reg_wdata,
  reg_rdata,
  reg_rvalid,
  port_irq_stat,
  port7_rx_strap_pin,
  spi_clk_fast,
  irq_out,
  miim_pre_sup,
  spi_out_rise,
  ref_clock_out_en,
  ref_clock_out_125,
  inband_mgmt_en,
  inband_mgmt_mac_chk,
  inband_mgmt_reset,
  inband_mgmt_queue,
  inband_mgmt_port,
  inband_mgmt_port_ok,
  inband_mgmt_etype
);
  input wire clk;
  input wire rst_b;
  input wire [`GIM_ADDR_W-1:0] reg_addr;
  input wire reg_wr;
  input wire reg_rd;
  input wire [31:0] reg_wdata;
  output reg [31:0] reg_rdata;
  output reg reg_rvalid;
  input wire [`GIM_NPORT-1:0] port_irq_stat;
  input wire port7_rx_strap_pin;
  input wire spi_clk_fast;
  output reg irq_out;
  output reg miim_pre_sup;
  output reg spi_out_rise;
  output reg ref_clock_out_en;
  output reg ref_clock_out_125;
  output reg inband_mgmt_en;
  output reg inband_mgmt_mac_chk;
  output reg inband_mgmt_reset;
  output reg [1:0] inband_mgmt_queue;
  output reg [2:0] inband_mgmt_port;
  output reg inband_mgmt_port_ok;
  output reg [15:0] inband_mgmt_etype;

  // ****************************************
  // storage
  // ****************************************
  reg [`GIM_NPORT-1:0] mask_q;
  reg [`GIM_NPORT-1:0] mask_d;
  reg [7:0] sio_q;
  reg [7:0] sio_d;
  reg [2:0] ock_rsv_q;
  reg [2:0] ock_rsv_d;
  reg ock_en_q;
  reg ock_en_d;
  reg ock_freq_q;
  reg ock_freq_d;
  reg ibm_en_q;
  reg ibm_en_d;
  reg ibm_chk_q;
  reg ibm_chk_d;
  reg [1:0] ibm_que_q;
  reg [1:0] ibm_que_d;
  reg [2:0] ibm_port_q;
  reg [2:0] ibm_port_d;
  reg [15:0] ibm_etype_q;
  reg [15:0] ibm_etype_d;
  reg strap_taken_q;
  reg strap_taken_d;
  reg [31:0] rd_d;
  wire strap_val;
  wire strap_done;
  wire wr_mask;
  wire wr_sio;
  wire wr_ock;
  wire wr_ibm;
  wire stat_hit;

  // ****************************************
  // strap capture
  // ****************************************
  gim_strap u_strap (
    .clk(clk),
    .rst_b(rst_b),
    .strap_in(port7_rx_strap_pin),
    .strap_val(strap_val),
    .strap_done(strap_done)
  );

  // ****************************************
  // address decode
  // ****************************************
  function hit;
    input [`GIM_ADDR_W-1:0] a;
    input [`GIM_ADDR_W-1:0] ofs;
    begin
      hit = (a == ofs);
    end
  endfunction

  assign wr_mask = reg_wr && hit(reg_addr, `GIM_OFS_PORT_IRQ_MASK);
  assign wr_sio = reg_wr && hit(reg_addr, `GIM_OFS_SERIAL_IO);
  assign wr_ock = reg_wr && hit(reg_addr, `GIM_OFS_OUT_CLK);
  assign wr_ibm = reg_wr && hit(reg_addr, `GIM_OFS_INBAND);
  assign stat_hit = hit(reg_addr, `GIM_OFS_PORT_IRQ_STAT);

  // ****************************************
  // port interrupt mask
  // ****************************************
  always @* begin
    mask_d = mask_q;
    if (wr_mask) begin
      mask_d = reg_wdata[`GIM_NPORT-1:0];
    end
  end

  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      mask_q <= `GIM_RST_PORT_IRQ_MASK;
    end else begin
      mask_q <= mask_d;
    end
  end

  // ****************************************
  // serial io control
  // ****************************************
  // reserved bits 7:3 are stored and read back as written
  always @* begin
    sio_d = sio_q;
    if (wr_sio) begin
      sio_d = reg_wdata[`GIM_SIO_RSV_MSB:`GIM_SIO_MAN_EDGE];
    end
  end

  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      sio_q <= `GIM_RST_SIO;
    end else begin
      sio_q <= sio_d;
    end
  end

  // ****************************************
  // output clock control
  // ****************************************
  always @* begin
    ock_rsv_d = ock_rsv_q;
    ock_en_d = ock_en_q;
    ock_freq_d = ock_freq_q;
    if (wr_ock) begin
      ock_rsv_d = reg_wdata[`GIM_OCK_RW_MSB:`GIM_OCK_RW_LSB];
      ock_en_d = reg_wdata[`GIM_OCK_EN];
      ock_freq_d = reg_wdata[`GIM_OCK_FREQ];
    end
  end

  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      ock_rsv_q <= `GIM_RST_OCK_RSV;
      ock_en_q <= `GIM_RST_OCK_EN;
      ock_freq_q <= `GIM_RST_OCK_FREQ;
    end else begin
      ock_rsv_q <= ock_rsv_d;
      ock_en_q <= ock_en_d;
      ock_freq_q <= ock_freq_d;
    end
  end

  // ****************************************
  // inband_mgmt control
  // ****************************************
  // strap level is loaded once; a register write in that same cycle wins
  always @* begin
    strap_taken_d = strap_taken_q;
    ibm_en_d = ibm_en_q;
    ibm_chk_d = ibm_chk_q;
    ibm_que_d = ibm_que_q;
    ibm_port_d = ibm_port_q;
    ibm_etype_d = ibm_etype_q;
    if (strap_done && !strap_taken_q) begin
      strap_taken_d = 1'b1;
      ibm_en_d = strap_val;
    end
    if (wr_ibm) begin
      ibm_en_d = reg_wdata[`GIM_IBM_EN];
      ibm_chk_d = reg_wdata[`GIM_IBM_MAC_CHK];
      ibm_que_d = reg_wdata[`GIM_IBM_QUE_MSB:`GIM_IBM_QUE_LSB];
      ibm_port_d = reg_wdata[`GIM_IBM_PORT_MSB:`GIM_IBM_PORT_LSB];
      ibm_etype_d = reg_wdata[`GIM_IBM_ETYPE_MSB:`GIM_IBM_ETYPE_LSB];
    end
  end

  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      strap_taken_q <= 1'b0;
      ibm_en_q <= `GIM_RST_IBM_EN;
      ibm_chk_q <= `GIM_RST_IBM_MAC_CHK;
      ibm_que_q <= `GIM_RST_IBM_QUE;
      ibm_port_q <= `GIM_RST_IBM_PORT;
      ibm_etype_q <= `GIM_RST_IBM_ETYPE;
    end else begin
      strap_taken_q <= strap_taken_d;
      ibm_en_q <= ibm_en_d;
      ibm_chk_q <= ibm_chk_d;
      ibm_que_q <= ibm_que_d;
      ibm_port_q <= ibm_port_d;
      ibm_etype_q <= ibm_etype_d;
    end
  end

  // ****************************************
  // read back
  // ****************************************
  always @* begin
    rd_d = 32'h0;
    if (stat_hit) begin
      rd_d[`GIM_NPORT-1:0] = port_irq_stat;
    end else if (hit(reg_addr, `GIM_OFS_PORT_IRQ_MASK)) begin
      rd_d[`GIM_NPORT-1:0] = mask_q;
    end else if (hit(reg_addr, `GIM_OFS_SERIAL_IO)) begin
      rd_d[`GIM_SIO_RSV_MSB:`GIM_SIO_MAN_EDGE] = sio_q;
    end else if (hit(reg_addr, `GIM_OFS_OUT_CLK)) begin
      rd_d[`GIM_OCK_RW_MSB:`GIM_OCK_FREQ] = {ock_rsv_q, ock_en_q, ock_freq_q};
    end else if (hit(reg_addr, `GIM_OFS_INBAND)) begin
      rd_d[`GIM_IBM_EN] = ibm_en_q;
      rd_d[`GIM_IBM_MAC_CHK] = ibm_chk_q;
      rd_d[`GIM_IBM_RESET] = inband_mgmt_reset;
      rd_d[`GIM_IBM_QUE_MSB:`GIM_IBM_QUE_LSB] = ibm_que_q;
      rd_d[`GIM_IBM_PORT_MSB:`GIM_IBM_PORT_LSB] = ibm_port_q;
      rd_d[`GIM_IBM_ETYPE_MSB:`GIM_IBM_ETYPE_LSB] = ibm_etype_q;
    end
  end

  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      reg_rdata <= 32'h0;
      reg_rvalid <= 1'b0;
    end else begin
      reg_rvalid <= reg_rd;
      if (reg_rd) begin
        reg_rdata <= rd_d;
      end
    end
  end

  // ****************************************
  // combined port interrupt
  // ****************************************
  // a port passes only while its mask bit is zero
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      irq_out <= 1'b0;
    end else begin
      irq_out <= |(port_irq_stat & ~mask_q);
    end
  end

  // ****************************************
  // serial io outputs
  // ****************************************
  // with automatic selection the manual bit is ignored
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      miim_pre_sup <= 1'b0;
      spi_out_rise <= 1'b0;
    end else begin
      miim_pre_sup <= sio_q[`GIM_SIO_PRE_SUP];
      spi_out_rise <= sio_q[`GIM_SIO_AUTO_EDGE] ? spi_clk_fast : sio_q[`GIM_SIO_MAN_EDGE];
    end
  end

  // ****************************************
  // reference clock outputs
  // ****************************************
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      ref_clock_out_en <= `GIM_RST_OCK_EN;
      ref_clock_out_125 <= `GIM_RST_OCK_FREQ;
    end else begin
      ref_clock_out_en <= ock_en_q;
      ref_clock_out_125 <= ock_freq_q;
    end
  end

  // ****************************************
  // inband_mgmt outputs
  // ****************************************
  // reinit is a one-cycle pulse; code 111 names no port and is flagged
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      inband_mgmt_en <= `GIM_RST_IBM_EN;
      inband_mgmt_mac_chk <= `GIM_RST_IBM_MAC_CHK;
      inband_mgmt_reset <= `GIM_RST_IBM_RESET;
      inband_mgmt_queue <= `GIM_RST_IBM_QUE;
      inband_mgmt_port <= `GIM_RST_IBM_PORT;
      inband_mgmt_port_ok <= 1'b1;
      inband_mgmt_etype <= `GIM_RST_IBM_ETYPE;
    end else begin
      inband_mgmt_en <= ibm_en_q;
      inband_mgmt_mac_chk <= ibm_chk_q;
      inband_mgmt_reset <= wr_ibm && reg_wdata[`GIM_IBM_RESET];
      inband_mgmt_queue <= ibm_que_q;
      inband_mgmt_port <= ibm_port_q;
      inband_mgmt_port_ok <= (ibm_port_q != `GIM_IBM_PORT_RSV);
      inband_mgmt_etype <= ibm_etype_q;
    end
  end
endmodule

/* gim_regs.vh */
// register offsets, field positions and reset values of the global io and port interrupt mask bank
`ifndef GIM_REGS_VH
`define GIM_REGS_VH
`define GIM_ADDR_W 16
`define GIM_OFS_PORT_IRQ_MASK 16'h001c
`define GIM_OFS_SERIAL_IO 16'h0100
`define GIM_OFS_OUT_CLK 16'h0103
`define GIM_OFS_INBAND 16'h0104
`define GIM_OFS_PORT_IRQ_STAT 16'h0018
`define GIM_NPORT 7
`define GIM_RST_PORT_IRQ_MASK 7'h00
`define GIM_SIO_RSV_LSB 3
`define GIM_SIO_RSV_MSB 7
`define GIM_RST_SIO_RSV 5'h08
`define GIM_SIO_PRE_SUP 2
`define GIM_SIO_AUTO_EDGE 1
`define GIM_SIO_MAN_EDGE 0
`define GIM_RST_SIO 8'h42
`define GIM_OCK_RW_LSB 2
`define GIM_OCK_RW_MSB 4
`define GIM_OCK_EN 1
`define GIM_OCK_FREQ 0
`define GIM_RST_OCK 5'h02
`define GIM_RST_OCK_RSV 3'h0
`define GIM_RST_OCK_EN 1'b1
`define GIM_RST_OCK_FREQ 1'b0
`define GIM_IBM_EN 31
`define GIM_IBM_MAC_CHK 30
`define GIM_IBM_RESET 29
`define GIM_IBM_QUE_MSB 23
`define GIM_IBM_QUE_LSB 22
`define GIM_IBM_PORT_MSB 18
`define GIM_IBM_PORT_LSB 16
`define GIM_IBM_ETYPE_MSB 15
`define GIM_IBM_ETYPE_LSB 0
`define GIM_RST_IBM_QUE 2'h1
`define GIM_RST_IBM_PORT 3'h6
`define GIM_RST_IBM_ETYPE 16'h40fe
`define GIM_RST_IBM_EN 1'b0
`define GIM_RST_IBM_MAC_CHK 1'b0
`define GIM_RST_IBM_RESET 1'b0
`define GIM_IBM_PORT_RSV 3'h7
`endif

/* gim_strap.v */
// strap capture: samples the port seven strap pin once after reset release
`timescale 1ns/100ps
module gim_strap (
  clk,
  rst_b,
  strap_in,
  strap_val,
  strap_done
);
  input wire clk;
  input wire rst_b;
  input wire strap_in;
  output reg strap_val;
  output reg strap_done;

  // first clock after release takes the pin level and then holds it
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      strap_val <= 1'b0;
      strap_done <= 1'b0;
    end else if (!strap_done) begin
      strap_val <= strap_in;
      strap_done <= 1'b1;
    end
  end
endmodule

/* tb_top.sv */
// register bank testbench
`timescale 1ns/100ps
module tb_top;
  reg clk = 0, rst_b = 0, reg_wr = 0, reg_rd = 0, spi_clk_fast = 0, i2c = 0, want = 0;
  reg [15:0] reg_addr = 0;
  reg [31:0] reg_wdata = 0;
  reg [6:0] pend = 0;
  wire [31:0] reg_rdata;
  wire [6:0] port_irq_stat;
  wire [2:0] inband_mgmt_port;
  wire [1:0] inband_mgmt_queue;
  wire [15:0] inband_mgmt_etype;
  wire port7_rx_strap_pin, reg_rvalid, irq_out, miim_pre_sup, spi_out_rise, ref_clock_out_en;
  wire ref_clock_out_125, inband_mgmt_en, inband_mgmt_mac_chk, inband_mgmt_reset, inband_mgmt_port_ok;
  integer n_errors = 0, total_checks = 0, cyc = 0, i;
  gim_port_src src (.pend(pend), .strap_want(want), .i2c_mode(i2c), .port_irq_stat, .port7_rx_strap_pin);
  gim_regbank uut (.clk, .rst_b, .reg_addr, .reg_wr, .reg_rd, .reg_wdata, .reg_rdata, .reg_rvalid,
    .port_irq_stat, .port7_rx_strap_pin, .spi_clk_fast, .irq_out, .miim_pre_sup, .spi_out_rise,
    .ref_clock_out_en, .ref_clock_out_125, .inband_mgmt_en, .inband_mgmt_mac_chk, .inband_mgmt_reset,
    .inband_mgmt_queue, .inband_mgmt_port, .inband_mgmt_port_ok, .inband_mgmt_etype);
  // ****************
  // tasks
  // ****************
  task chk(input string nm, input [31:0] got, input [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task wr(input [15:0] a, input [31:0] v);
    @(negedge clk); reg_wr = 1; reg_addr = a; reg_wdata = v;
    @(negedge clk); reg_wr = 0;
  endtask
  task rd(input [15:0] a, input [31:0] e);
    @(negedge clk); reg_rd = 1; reg_addr = a;
    @(negedge clk); reg_rd = 0;
    chk("rvalid", reg_rvalid, 1);
    chk("rdata", reg_rdata, e);
  endtask
  task do_reset(input s);
    rst_b = 0; want = s;
    repeat (16) @(negedge clk);
    rst_b = 1;
    repeat (3) @(negedge clk);
  endtask
  task print_verdict;
    $display("checks %0d mismatches %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  initial forever #2.5 clk = ~clk;
  always @(posedge clk) begin
    cyc++;
    if (cyc == 5000) begin
      n_errors++;
      print_verdict;
    end
  end
  initial begin
    do_reset(1);
    rd(16'h001c, 0);
    rd(16'h0100, 32'h42);
    rd(16'h0103, 32'h02);
    rd(16'h0104, 32'h804640fe);
    rd(16'h0200, 0);
    chk("rise", spi_out_rise, 0);
    $display("test reset done");
    for (i = 0; i < 7; i++) begin
      wr(16'h001c, 32'hffffff80 | (1 << i)); pend = 7'h1 << i;
      @(negedge clk); chk("irq masked", irq_out, 0);
      pend = 7'h7f;
      @(negedge clk); chk("irq open", irq_out, 1);
      rd(16'h001c, 1 << i);
    end
    wr(16'h0018, 32'hffffffff); rd(16'h0018, 32'h7f);
    pend = 0; wr(16'h001c, 0); rd(16'h0018, 0);
    $display("test irq done");
    for (i = 0; i < 16; i++) begin
      spi_clk_fast = i[3]; wr(16'h0100, 32'h40 | i[2:0]);
      @(negedge clk); chk("presup", miim_pre_sup, i[2]);
      chk("rise", spi_out_rise, i[1] ? i[3] : i[0]);
      rd(16'h0100, 32'h40 | i[2:0]);
    end
    for (i = 0; i < 4; i++) begin
      wr(16'h0103, 32'hfc | i); @(negedge clk);
      chk("clk en", ref_clock_out_en, i[1]); chk("clk 125", ref_clock_out_125, i[0]);
      rd(16'h0103, 32'h1c | i);
    end
    $display("test serial done");
    wr(16'h0104, 32'h7fc51234); chk("pulse", inband_mgmt_reset, 1);
    @(negedge clk); chk("pulse", inband_mgmt_reset, 0); chk("en", inband_mgmt_en, 0);
    chk("mac", inband_mgmt_mac_chk, 1); chk("que", inband_mgmt_queue, 3);
    chk("port", inband_mgmt_port, 5); chk("ok", inband_mgmt_port_ok, 1);
    chk("etype", inband_mgmt_etype, 16'h1234); rd(16'h0104, 32'h40c51234);
    wr(16'h0104, 32'h80378765); @(negedge clk); chk("ok", inband_mgmt_port_ok, 0);
    rd(16'h0104, 32'h80078765);
    i2c = 1; do_reset(1); rd(16'h0104, 32'h004640fe);
    $display("test inband done");
    print_verdict;
  end
endmodule
